// *** hdl/adc_parallel_strobe_sequencer.sv ***
`timescale 1ns/1ps
// strobe sequencer and three-state read port of the converter
// Contract
// - result is a 16-bit three-state word, bit 15 most significant
// - first strobe fall with select low powers up into acquisition
// - select high at second fall powers reference down after conversion
// - select low at second fall keeps reference powered after conversion
// - select high at third fall drives the result onto the bus
// - done output goes low when conversion completes
// - second strobe fall starts the conversion
// - byte mode: high-byte select 1 gives MSB, 0 gives LSB
// - reset input high returns the device to reset state
module adc_parallel_strobe_sequencer #(
  parameter int CONV_CYCLES = adc_seq_pkg::CONV_CYCLES,
  parameter bit BYTE_MODE = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // host strobes
  input wire logic strobe_n,
  input wire logic read_sel,
  input wire logic high_byte_select,
  // result from the analog core
  input wire logic [adc_seq_pkg::DATA_W-1:0] sample_data,
  // status
  output logic conv_done_n,
  output logic powered,
  output logic ref_on,
  // data bus
  output logic [adc_seq_pkg::DATA_W-1:0] data_out,
  output logic data_oe
);
  import adc_seq_pkg::*;
  seq_state_t state;
  logic strobe_d;
  logic fall;
  logic ref_down_req;
  logic [DATA_W-1:0] result;
  adc_sample_if conv ();

  adc_conv_timer #(.CYCLES(CONV_CYCLES)) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .conv(conv)
  );

  // strobe edge detect
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strobe_d <= 1'b1;
    end else begin
      strobe_d <= strobe_n;
    end
  end
  assign fall = strobe_d && !strobe_n;
  assign conv.start = fall && (state == ST_ACQ);

  // sequence of strobe falls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_OFF;
    end else begin
      case (state)
        ST_OFF: begin
          if (fall && !read_sel) begin
            state <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (fall) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv.done) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (fall && read_sel) begin
            state <= ST_READ;
          end
        end
        ST_READ: begin
          if (strobe_n) begin
            state <= ST_OFF;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // reference power choice, sampled at the second fall
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_down_req <= 1'b0;
      ref_on <= 1'b0;
      powered <= 1'b0;
    end else begin
      if (state == ST_OFF && fall && !read_sel) begin
        powered <= 1'b1;
        ref_on <= 1'b1;
      end
      if (conv.start) begin
        ref_down_req <= read_sel;
      end
      if (conv.done) begin
        ref_on <= !ref_down_req;
        powered <= !ref_down_req;
      end
    end
  end

  // result latch and done flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result <= DATA_RESET;
      conv_done_n <= 1'b1;
    end else begin
      if (conv.done) begin
        result <= sample_data;
        conv_done_n <= 1'b0;
      end else if (state == ST_READ && strobe_n) begin
        conv_done_n <= 1'b1;
      end
    end
  end

  // bus drive: full word or selected byte in low lanes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_out <= DATA_RESET;
      data_oe <= 1'b0;
    end else begin
      data_oe <= (state == ST_READ) && !strobe_n;
      if (!BYTE_MODE) begin
        data_out <= result;
      end else if (high_byte_select) begin
        data_out <= {{BYTE_W{1'b0}}, result[MSB_POS -: BYTE_W]};
      end else begin
        data_out <= {{BYTE_W{1'b0}}, result[BYTE_W-1:0]};
      end
    end
  end

  // checker copy of the select level taken at the convert fall
  logic chk_sel;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chk_sel <= 1'b0;
    end else if (state == ST_ACQ && fall) begin
      chk_sel <= read_sel;
    end
  end

  // checks
  property p_start_on_second;
    @(posedge clk_sys) disable iff (rst)
      (state == ST_ACQ && fall) |=> (state == ST_CONV) && conv.busy;
  endproperty
  a_start_on_second: assert property (p_start_on_second) else $error("no start");
  property p_done_low;
    @(posedge clk_sys) disable iff (rst)
      conv.done |=> !conv_done_n && result == $past(sample_data);
  endproperty
  a_done_low: assert property (p_done_low) else $error("done not low");
  // end of a conversion whose convert fall asked for power-down
  sequence s_end_ref_down;
    conv.done && chk_sel;
  endsequence
  // end of a conversion whose convert fall asked to keep the reference
  sequence s_end_ref_keep;
    conv.done && !chk_sel;
  endsequence
  property p_ref_down;
    @(posedge clk_sys) disable iff (rst)
      s_end_ref_down |=> !ref_on && !powered;
  endproperty
  a_ref_down: assert property (p_ref_down) else $error("ref stays on");
  property p_ref_keep;
    @(posedge clk_sys) disable iff (rst)
      s_end_ref_keep |=> ref_on && powered;
  endproperty
  a_ref_keep: assert property (p_ref_keep) else $error("ref dropped");
  property p_powerup;
    @(posedge clk_sys) disable iff (rst)
      (state == ST_OFF && fall && !read_sel) |=> powered && state == ST_ACQ;
  endproperty
  a_powerup: assert property (p_powerup) else $error("no power up");
  sequence s_read_fall;
    state == ST_DONE && fall && read_sel;
  endsequence
  property p_read;
    @(posedge clk_sys) disable iff (rst)
      s_read_fall ##1 !strobe_n |=> data_oe;
  endproperty
  a_read: assert property (p_read) else $error("bus not driven");
  property p_release;
    @(posedge clk_sys) disable iff (rst)
      data_oe |-> $past(state == ST_READ) && $past(!strobe_n);
  endproperty
  a_release: assert property (p_release) else $error("bus driven idle");
  property p_word;
    @(posedge clk_sys) disable iff (rst)
      (!BYTE_MODE && data_oe) |-> data_out == result;
  endproperty
  a_word: assert property (p_word) else $error("bad word");
  property p_byte_pick;
    @(posedge clk_sys) disable iff (rst)
      (BYTE_MODE && data_oe) |-> data_out[DATA_W-1:BYTE_W] == '0 &&
        data_out[BYTE_W-1:0] == ($past(high_byte_select) ?
          $past(result[MSB_POS -: BYTE_W]) : $past(result[BYTE_W-1:0]));
  endproperty
  a_byte_pick: assert property (p_byte_pick) else $error("bad byte");
  property p_let_go;
    @(posedge clk_sys) disable iff (rst)
      (state == ST_READ && strobe_n) |=> !data_oe;
  endproperty
  a_let_go: assert property (p_let_go) else $error("bus held after strobe");
  property p_reset_state;
    @(posedge clk_sys) rst |=> state == ST_OFF && !data_oe;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset ignored");
endmodule

// *** hdl/adc_seq_pkg.sv ***
// package of constants and types for the converter strobe sequencer
package adc_seq_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int MSB_POS = 15;
  // conversion time in ns as printed (longest), and cycles at 250 MHz
  localparam int CONV_TIME_NS = 4700;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 13;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_ACQ = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b011,
    ST_READ = 3'b100
  } seq_state_t;
endpackage

// *** hdl/adc_sample_if.sv ***
`timescale 1ns/1ps
// interface between sequencer and conversion timer
interface adc_sample_if;
  logic start;
  logic busy;
  logic done;
  modport seq (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface

// *** hdl/adc_conv_timer.sv ***
`timescale 1ns/1ps
// self-timed conversion counter, pulses done after the conversion time
module adc_conv_timer #(
  parameter int CYCLES = adc_seq_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link to sequencer
  adc_sample_if.timer conv
);
  import adc_seq_pkg::*;
  logic [CNT_W-1:0] count;
  logic run;

  // count down from start, pulse done on the last cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= '0;
      run <= 1'b0;
      conv.done <= 1'b0;
    end else begin
      conv.done <= 1'b0;
      if (conv.start && !run) begin
        count <= CNT_W'(CYCLES - 1);
        run <= 1'b1;
      end else if (run) begin
        if (count == '0) begin
          run <= 1'b0;
          conv.done <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
  assign conv.busy = run;
endmodule

// *** dv/adc_host_model.sv ***
`timescale 1ns/1ps
// host model driving the convert strobe and read/convert select
module adc_host_model (
  // clock
  input wire logic clk_sys,
  // strobes toward the sequencer
  output logic strobe_n,
  output logic read_sel
);
  initial begin
    strobe_n = 1'b1;
    read_sel = 1'b0;
  end
  // strobe falls and the select level is set in the same step, then held
  task automatic fall(input logic rs);
    @(posedge clk_sys);
    #1;
    strobe_n = 1'b0;
    read_sel = rs;
  endtask
  // strobe rises; select flips in the same step as the rise
  task automatic rise();
    @(posedge clk_sys);
    #1;
    strobe_n = 1'b1;
    read_sel = ~read_sel;
  endtask
endmodule

// *** dv/tb_adc_parallel_strobe_sequencer.sv ***
`timescale 1ns/1ps
// self-checking bench for the strobe sequencer, word and byte variants
module tb_adc_parallel_strobe_sequencer;
  import adc_seq_pkg::*;
  localparam int CONV = 10;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic high_byte_select = 1'b0;
  logic [DATA_W-1:0] sample_data = 16'h0000;
  logic strobe_n, read_sel, conv_done_n, powered, ref_on, data_oe;
  logic b_done_n, b_pow, b_ref, b_oe;
  logic [DATA_W-1:0] data_out, b_data;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 32'had37;
  // clock at 250 MHz
  always #2 clk_sys = ~clk_sys;
  adc_host_model host (.clk_sys(clk_sys), .strobe_n(strobe_n), .read_sel(read_sel));
  adc_parallel_strobe_sequencer #(.CONV_CYCLES(CONV)) dut (.clk_sys(clk_sys), .rst(rst),
    .strobe_n(strobe_n), .read_sel(read_sel), .high_byte_select(high_byte_select),
    .sample_data(sample_data), .conv_done_n(conv_done_n), .powered(powered),
    .ref_on(ref_on), .data_out(data_out), .data_oe(data_oe));
  adc_parallel_strobe_sequencer #(.CONV_CYCLES(CONV), .BYTE_MODE(1'b1)) dut_byte (
    .clk_sys(clk_sys), .rst(rst), .strobe_n(strobe_n), .read_sel(read_sel),
    .high_byte_select(high_byte_select), .sample_data(sample_data),
    .conv_done_n(b_done_n), .powered(b_pow), .ref_on(b_ref), .data_out(b_data), .data_oe(b_oe));
  // compare a value against its expectation
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // byte placed on the low lanes in the byte variant
  function automatic logic [DATA_W-1:0] exp_byte(input logic [DATA_W-1:0] d, input logic hb);
    return hb ? {8'h00, d[15:8]} : {8'h00, d[7:0]};
  endfunction
  // one full power-up, convert and read sequence
  task automatic run_seq(input logic rs2, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    sample_data = d;
    host.fall(1'b0);
    host.rise();
    chk(powered, 1'b1);
    host.fall(rs2);
    host.rise();
    while (conv_done_n !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n, CONV + 1);
    chk(b_done_n, 1'b0);
    chk(ref_on, !rs2);
    chk(powered, !rs2);
    chk(data_oe, 1'b0);
    high_byte_select = $random(seed);
    host.fall(1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(data_oe, 1'b1);
    chk(data_out, d);
    chk(b_data, exp_byte(d, high_byte_select));
    high_byte_select = ~high_byte_select;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(b_data, exp_byte(d, high_byte_select));
    chk(data_oe, 1'b1);
    host.rise();
    @(posedge clk_sys);
    #1;
    chk(data_oe, 1'b0);
    chk(conv_done_n, 1'b1);
  endtask
  // verdict and end of run
  task automatic finish_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    host.fall(1'b1);
    host.rise();
    @(posedge clk_sys);
    #1;
    chk(powered, 1'b0);
    host.fall(1'b0);
    host.rise();
    rst = 1'b1;
    #1;
    chk({powered, ref_on, conv_done_n, data_oe}, 4'h2);
    @(posedge clk_sys);
    #1;
    rst = 1'b0;
    run_seq(1'b0, 16'h8000);
    run_seq(1'b1, 16'hFFFF);
    run_seq(1'b0, 16'h0001);
    repeat (8) run_seq($random(seed), $random(seed));
    finish_test();
  end
  // watchdog cutting a hang short
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule
